//--- hw/tstc_top.sv
// Functional notes
// - frame high opens, frame low aborts, releases data
// - sample on rising edge, drive after falling
// - data line released while serial clock high
// - commands and data shift lsb first
// - command aah reads nine temperature bits
// - commands 01h/02h write high/low limits
// - commands a1h/a2h read high/low limits
// - a0h reads counter, a9h reads slope
// - eeh starts one or continuous conversions
// - 22h stops after current conversion ends
// - 0ch writes config byte, ach reads it
// - done bit low from reset and while converting, else high
// - sticky trip flags, cleared by writing zero
// - eeprom busy flag high during nv write
// - host mode zero: pin starts conversions
// - one-shot bit selects single or continuous for the eeh start command; the stand-alone pin ignores it
// - one-shot outputs hold last conversion result
// - serial port works in both host modes
// - short low pulse triggers one conversion
// - held low pin runs continuous conversions
// - limits and temperature compared as signed
// - combo output has limit hysteresis
// - reads past the msb shift zeros
`timescale 1ns/100ps
`include "tstc_regs.svh"
module tstc_top
  import tstc_pkg::*;
#(
  parameter int NV_WRITE_CYC = `TSTC_NV_WRITE_CYC,  // eeprom write time in mclk cycles
  parameter int SA_PULSE_CYC = `TSTC_SA_PULSE_CYC   // stand-alone short pulse limit
) (
  input  wire logic       mclk,               // core clock, 100 MHz
  input  wire logic       rst,                // active high; synchronous in the core, asynchronous for the hand-over
  input  wire logic       frame,              // frame line from host, active high
  input  wire logic       clock_convert_pin,  // serial clock / convert input
  input  wire logic       dq_i,               // data line level
  output logic            dq_o,               // data line drive value
  output logic            dq_oe,              // data line drive enable
  output logic            conv_start,         // one-cycle start to the measuring core
  input  wire logic       conv_done,          // one-cycle end from the measuring core
  input  wire logic [8:0] conv_temp,          // result, two's complement half degrees
  input  wire logic [8:0] conv_count,         // count remaining
  input  wire logic [8:0] conv_slope,         // slope accumulator
  output logic            temp_high_out,      // over output
  output logic            temp_low_out,       // under output
  output logic            temp_combo_out      // hysteresis output
);

  // busy countdown stops at zero, so load one less
  localparam logic [`TSTC_CNT_W-1:0] NV_LOAD = `TSTC_CNT_W'(NV_WRITE_CYC - 1);
  // pin low this long counts as held, not pulsed
  localparam logic [`TSTC_CNT_W-1:0] SA_MAX  = `TSTC_CNT_W'(SA_PULSE_CYC);

  tstc_link_t lk, next_lk;       // link shifter
  tstc_hand_t hd, next_hd;       // link-to-core hand-over
  tstc_dout_t dout, next_dout;   // falling edge output stage
  tstc_core_t c, next_c;         // core state

  // shifter decode; the issue signals are read by the hand-over only
  logic        issue;            // link action complete this edge
  tstc_wkind_t issue_kind;       // which action
  logic [8:0]  issue_data;       // its data
  logic [7:0]  new_cmd;          // command with the current bit shifted in
  logic [8:0]  new_din;          // data with the current bit shifted in

  ////////////////////////////////////////////////////////////////////////////
  // link side, serial clock domain
  // runs only while the host clocks; frame low clears all but the hand-over
  // only the hand-over word leaves, and its toggle is
  // synchronised in the core before kind and data are read

  // pick the read word for a command; the core keeps these frozen during a frame
  // the snapshot settles a few mclk after frame rises,
  // long before the eighth rising edge reads it
  function automatic logic [9:0] rd_select(input logic [7:0] cmd, input tstc_core_t s);
    logic [9:0] r;
    r = 10'h000;
    case (cmd)
      `TSTC_CMD_RD_TEMP:  r = {1'b1, s.sh_temp};
      `TSTC_CMD_RD_COUNT: r = {1'b1, s.sh_count};
      `TSTC_CMD_RD_SLOPE: r = {1'b1, s.sh_slope};
      `TSTC_CMD_RD_HIGH:  r = {1'b1, s.sh_high};
      `TSTC_CMD_RD_LOW:   r = {1'b1, s.sh_low};
      // eight-bit byte: the ninth slot already reads zero
      `TSTC_CMD_RD_CFG:   r = {2'b10, s.sh_cfg};
      default:            r = 10'h000;                  // undefined codes do nothing
    endcase
    return r;
  endfunction

  // shifter next state, one bit per rising edge
  // bitn counts rises: 0..7 command, 8 on data
  // writes act on their last bit, so a cut frame is harmless
  always_comb begin
    next_lk    = lk;
    issue      = 1'b0;
    issue_kind = TSTC_WK_NONE;
    issue_data = 9'h000;
    new_cmd    = {dq_i, lk.cmd[7:1]};
    new_din    = {dq_i, lk.din[8:1]};
    // bit counter saturates so long reads never wrap
    // a wrap would restart the command phase mid-read
    if (lk.bitn != 5'h1f) begin
      next_lk.bitn = lk.bitn + 5'h01;
    end
    if (lk.bitn < `TSTC_CMD_BITS) begin
      next_lk.cmd = new_cmd;
    end
    if (lk.bitn == `TSTC_CMD_BITS - 5'h01) begin
      // last command bit: decode at once so the first read bit is ready
      {next_lk.rd_act, next_lk.rd} = rd_select(new_cmd, c);
      if (new_cmd == `TSTC_CMD_START) begin
        issue      = 1'b1;
        issue_kind = TSTC_WK_START;
      end else if (new_cmd == `TSTC_CMD_STOP) begin
        issue      = 1'b1;
        issue_kind = TSTC_WK_STOP;
      end
    end else if (lk.bitn >= `TSTC_CMD_BITS) begin
      next_lk.rd  = {1'b0, lk.rd[8:1]};
      next_lk.din = new_din;
      if (lk.bitn == `TSTC_LAST_WORD_BIT) begin
        if (lk.cmd == `TSTC_CMD_WR_HIGH) begin
          issue      = 1'b1;
          issue_kind = TSTC_WK_HIGH;
          issue_data = new_din;
        end else if (lk.cmd == `TSTC_CMD_WR_LOW) begin
          issue      = 1'b1;
          issue_kind = TSTC_WK_LOW;
          issue_data = new_din;
        end
      end
      if (lk.bitn == `TSTC_LAST_CFG_BIT && lk.cmd == `TSTC_CMD_WR_CFG) begin
        issue      = 1'b1;
        issue_kind = TSTC_WK_CFG;
        issue_data = {1'b0, new_din[8:1]};
      end
    end
  end

  // frame low clears the shifter at once, aborting any transfer
  // frame doubles as link reset, so no mclk is needed
  always_ff @(posedge clock_convert_pin or negedge frame) begin
    if (!frame) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // hand-over word: toggle marks a new action, data stays until the next one
  // kind and data move with the toggle and then hold, so
  // they are settled once the toggle is through two flops
  always_comb begin
    next_hd = hd;
    if (issue) begin
      next_hd.tog  = ~hd.tog;
      next_hd.kind = issue_kind;
      next_hd.data = issue_data;
    end
  end

  // kept across frames so the core can still read it after frame low
  // asynchronous reset: this clock may be idle during rst
  always_ff @(posedge clock_convert_pin or posedge rst) begin
    if (rst) begin
      hd <= '0;
    end else begin
      hd <= next_hd;
    end
  end

  // output stage loads on the falling edge, holds through the rising edge
  // the host gets the whole low half as set-up time
  always_comb begin
    next_dout.drv     = lk.rd_act;
    next_dout.bit_out = lk.rd[0];
  end

  // frame low drops the drive even with the clock stopped
  always_ff @(negedge clock_convert_pin or negedge frame) begin
    if (!frame) begin
      dout <= '0;
    end else begin
      dout <= next_dout;
    end
  end

  assign dq_o  = dout.bit_out;
  // trade-off: the one output not straight from a flop;
  // a flop would let go half a clock late, while high
  // enable is gated by the clock itself so it lets go as soon as the clock rises
  assign dq_oe = dout.drv & ~clock_convert_pin;

  ////////////////////////////////////////////////////////////////////////////
  // core side, mclk domain
  // frame, pin and toggle pass two flops each;
  // every input but kind and data is on mclk already

  logic standalone;   // pin acts as a convert input
  logic pin_fall;     // convert pin went low
  logic sa_hold;      // convert pin held low past the short pulse limit
  logic wr_new;       // a new hand-over action arrived
  logic hi_hit;       // result at or above high limit
  logic lo_hit;       // result at or below low limit

  // later assignments win, so the order is the priority:
  // sequencer, pin, serial actions, conversion end
  always_comb begin
    next_c = c;
    // two-stage synchronisers; only the second stage is read below
    // pin_d is a third stage, only for the falling edge
    next_c.fr_s1  = frame;
    next_c.fr_s2  = c.fr_s1;
    next_c.pin_s1 = clock_convert_pin;
    next_c.pin_s2 = c.pin_s1;
    next_c.pin_d  = c.pin_s2;
    next_c.wt_s1  = hd.tog;
    next_c.wt_s2  = c.wt_s1;
    next_c.conv_start = 1'b0;

    // stand-alone needs host mode off and no open frame
    standalone = ~c.host_mode & ~c.fr_s2;
    pin_fall   = standalone & c.pin_d & ~c.pin_s2;
    sa_hold    = standalone & ~c.pin_s2 & (c.sa_cnt >= SA_MAX);
    wr_new     = c.wt_s2 != c.wt_seen;
    hi_hit     = $signed(conv_temp) >= $signed(c.high_limit_register);
    lo_hit     = $signed(conv_temp) <= $signed(c.low_limit_register);

    // time how long the convert pin has stayed low
    // saturating, so a very long hold never wraps
    // back into looking like a short pulse
    if (standalone && !c.pin_s2) begin
      if (c.sa_cnt != SA_MAX) begin
        next_c.sa_cnt = c.sa_cnt + `TSTC_CNT_W'(1);
      end
    end else begin
      next_c.sa_cnt = '0;
    end

    // eeprom busy countdown
    // a write while busy reloads; the host should wait
    if (c.eeprom_busy_flag) begin
      if (c.nv_cnt == '0) begin
        next_c.eeprom_busy_flag = 1'b0;
      end else begin
        next_c.nv_cnt = c.nv_cnt - `TSTC_CNT_W'(1);
      end
    end

    // start of a conversion; clears pending first so a new request below wins
    // a held pin keeps starting even with one-shot set
    if (c.state == TSTC_IDLE && (c.pend || c.run || sa_hold)) begin
      next_c.state      = TSTC_CONV;
      next_c.conv_start = 1'b1;
      next_c.done       = 1'b0;
      next_c.pend       = 1'b0;
    end

    // stand-alone falling edge asks for one conversion
    if (pin_fall) begin
      next_c.pend = 1'b1;
    end

    // actions from the serial port
    // one action per frame, frames far apart: none lost
    if (wr_new) begin
      next_c.wt_seen = c.wt_s2;
      case (hd.kind)
        TSTC_WK_HIGH: begin
          next_c.high_limit_register = hd.data;
          next_c.eeprom_busy_flag    = 1'b1;
          next_c.nv_cnt              = NV_LOAD;
        end
        TSTC_WK_LOW: begin
          next_c.low_limit_register = hd.data;
          next_c.eeprom_busy_flag   = 1'b1;
          next_c.nv_cnt             = NV_LOAD;
        end
        TSTC_WK_CFG: begin
          // trip flags only clear on a zero; writing one leaves them alone
          // done and busy are status only; their bits are ignored
          next_c.high_trip_flag = c.high_trip_flag & hd.data[`TSTC_CFG_HIGH_TRIP];
          next_c.low_trip_flag  = c.low_trip_flag & hd.data[`TSTC_CFG_LOW_TRIP];
          next_c.host_mode      = hd.data[`TSTC_CFG_HOST_MODE];
          next_c.one_shot_bit   = hd.data[`TSTC_CFG_ONE_SHOT];
          next_c.eeprom_busy_flag = 1'b1;
          next_c.nv_cnt           = NV_LOAD;
        end
        TSTC_WK_START: begin
          if (c.one_shot_bit) begin
            next_c.pend = 1'b1;
          end else begin
            next_c.run = 1'b1;
          end
        end
        TSTC_WK_STOP: begin
          // the conversion already running is left to finish
          // a pending one-shot request is dropped as well
          next_c.run  = 1'b0;
          next_c.pend = 1'b0;
        end
        default: begin
          // nothing new or an undefined code: keep sequencer
          next_c.run = c.run;
        end
      endcase
    end

    // end of a conversion; placed last so its flag sets beat a clear
    // a done pulse while idle is ignored
    if (c.state == TSTC_CONV && conv_done) begin
      next_c.state = TSTC_IDLE;
      next_c.temp  = conv_temp;
      next_c.count = conv_count;
      next_c.slope = conv_slope;
      next_c.done  = 1'b1;
      if (hi_hit) begin
        next_c.high_trip_flag = 1'b1;
      end
      if (lo_hit) begin
        next_c.low_trip_flag = 1'b1;
      end
      // outputs move only here, so between conversions they hold
      next_c.out_high = hi_hit;
      next_c.out_low  = lo_hit;
      // between the limits combo keeps its last level
      if (hi_hit) begin
        next_c.out_combo = 1'b1;
      end else if (lo_hit) begin
        next_c.out_combo = 1'b0;
      end
    end

    // snapshot for the link, frozen while a frame is open
    // reads return values as they stood at frame open
    if (!c.fr_s2) begin
      next_c.sh_temp  = c.temp;
      next_c.sh_count = c.count;
      next_c.sh_slope = c.slope;
      next_c.sh_high  = c.high_limit_register;
      next_c.sh_low   = c.low_limit_register;
      next_c.sh_cfg   = {c.done, c.high_trip_flag, c.low_trip_flag, c.eeprom_busy_flag,
                         1'b1, 1'b0, c.host_mode, c.one_shot_bit};
    end
  end

  // core register, synchronous reset
  // limits and modes start at shipped defaults
  always_ff @(posedge mclk) begin
    if (rst) begin
      c                     <= '0;
      c.high_limit_register <= `TSTC_HIGH_RST;
      c.low_limit_register  <= `TSTC_LOW_RST;
      c.host_mode           <= `TSTC_HOST_MODE_RST;
      c.one_shot_bit        <= `TSTC_ONE_SHOT_RST;
      c.state               <= TSTC_IDLE;
      c.sh_cfg              <= 8'h08;
      // pin idles high; a high history avoids a false edge
      c.pin_s1              <= 1'b1;
      c.pin_s2              <= 1'b1;
      c.pin_d               <= 1'b1;
    end else begin
      c <= next_c;
    end
  end

  // all four come straight from core flops
  assign conv_start     = c.conv_start;
  assign temp_high_out  = c.out_high;
  assign temp_low_out   = c.out_low;
  assign temp_combo_out = c.out_combo;

endmodule

//--- hw/tstc_regs.svh
`ifndef TSTC_REGS_SVH
`define TSTC_REGS_SVH

// serial command codes, shifted lsb first
`define TSTC_CMD_RD_TEMP   8'haa
`define TSTC_CMD_RD_COUNT  8'ha0
`define TSTC_CMD_RD_SLOPE  8'ha9
`define TSTC_CMD_WR_HIGH   8'h01
`define TSTC_CMD_WR_LOW    8'h02
`define TSTC_CMD_RD_HIGH   8'ha1
`define TSTC_CMD_RD_LOW    8'ha2
`define TSTC_CMD_START     8'hee
`define TSTC_CMD_STOP      8'h22
`define TSTC_CMD_WR_CFG    8'h0c
`define TSTC_CMD_RD_CFG    8'hac

// configuration_status bit positions
`define TSTC_CFG_DONE      7
`define TSTC_CFG_HIGH_TRIP 6
`define TSTC_CFG_LOW_TRIP  5
`define TSTC_CFG_EE_BUSY   4
`define TSTC_CFG_FIXED1    3
`define TSTC_CFG_FIXED0    2
`define TSTC_CFG_HOST_MODE 1
`define TSTC_CFG_ONE_SHOT  0

// bit counts on the link
`define TSTC_CMD_BITS      5'h08
`define TSTC_LAST_WORD_BIT 5'h10
`define TSTC_LAST_CFG_BIT  5'h0f

// nonvolatile defaults and limit defaults
`define TSTC_HOST_MODE_RST 1'h0
`define TSTC_ONE_SHOT_RST  1'h0
`define TSTC_HIGH_RST      9'h000
`define TSTC_LOW_RST       9'h000

// timing
`define TSTC_MCLK_KHZ      100000
`define TSTC_NV_WRITE_MS   10
`define TSTC_SA_PULSE_MS   10
`define TSTC_NV_WRITE_CYC  (`TSTC_NV_WRITE_MS * `TSTC_MCLK_KHZ)
`define TSTC_SA_PULSE_CYC  (`TSTC_SA_PULSE_MS * `TSTC_MCLK_KHZ)
`define TSTC_CNT_W         24

`endif

//--- hw/tstc_pkg.sv
package tstc_pkg;
  `include "tstc_regs.svh"

  // conversion sequencer states
  typedef enum logic [0:0] {
    TSTC_IDLE = 1'b0,
    TSTC_CONV = 1'b1
  } tstc_conv_t;

  // actions handed from the link to the core
  typedef enum logic [2:0] {
    TSTC_WK_NONE  = 3'b000,
    TSTC_WK_HIGH  = 3'b001,
    TSTC_WK_LOW   = 3'b010,
    TSTC_WK_CFG   = 3'b011,
    TSTC_WK_START = 3'b100,
    TSTC_WK_STOP  = 3'b101
  } tstc_wkind_t;

  // link shifter, cleared whenever the frame line is low
  typedef struct packed {
    logic [4:0] bitn;
    logic [7:0] cmd;
    logic [8:0] din;
    logic [8:0] rd;
    logic       rd_act;
  } tstc_link_t;

  // link hand-over word, survives frame ends
  typedef struct packed {
    logic        tog;
    tstc_wkind_t kind;
    logic [8:0]  data;
  } tstc_hand_t;

  // falling-edge output stage
  typedef struct packed {
    logic drv;
    logic bit_out;
  } tstc_dout_t;

  // core state on mclk
  typedef struct packed {
    logic                     fr_s1, fr_s2;
    logic                     pin_s1, pin_s2, pin_d;
    logic                     wt_s1, wt_s2, wt_seen;
    logic [8:0]               high_limit_register, low_limit_register;
    logic [8:0]               temp, count, slope;
    logic                     done, high_trip_flag, low_trip_flag, eeprom_busy_flag;
    logic                     host_mode, one_shot_bit;
    logic [`TSTC_CNT_W-1:0]   nv_cnt, sa_cnt;
    tstc_conv_t               state;
    logic                     run, pend, conv_start;
    logic                     out_high, out_low, out_combo;
    logic [8:0]               sh_temp, sh_count, sh_slope, sh_high, sh_low;
    logic [7:0]               sh_cfg;
  } tstc_core_t;
endpackage

//--- bench/tstc_checker.sv
`timescale 1ns/100ps
module tstc_checker
  import tstc_pkg::*;
#(
  parameter int NV_WRITE_CYC = 20,  // eeprom busy span, unused here
  parameter int SA_PULSE_CYC = 30   // stand-alone pulse limit, unused here
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       frame,
  input wire logic       clock_convert_pin,
  input wire logic       dq_i,
  input wire logic       dq_o,
  input wire logic       dq_oe,
  input wire logic       conv_start,
  input wire logic       conv_done,
  input wire logic [8:0] conv_temp,
  input wire logic [8:0] conv_count,
  input wire logic [8:0] conv_slope,
  input wire logic       temp_high_out,
  input wire logic       temp_low_out,
  input wire logic       temp_combo_out
);
  logic busy;  // a conversion is in flight between start and done

  ////////////////////////////////////////////////////////////////
  // track the measuring core handshake
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy <= 1'b0;
    end else if (conv_start) begin
      busy <= 1'b1;
    end else if (conv_done) begin
      busy <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////
  // link drive rules
  chk_frame_release: assert property (!frame |-> !dq_oe)
    else $error("data line driven while frame low");
  chk_clock_release: assert property (clock_convert_pin |-> !dq_oe)
    else $error("data line driven while serial clock high");

  ////////////////////////////////////////////////////////////////
  // conversion sequencing
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start held longer than one cycle");
  chk_done_gap: assert property (conv_done |-> !conv_start)
    else $error("start in the same cycle as done");
  chk_single_conv: assert property (busy |-> !conv_start)
    else $error("second start before the first conversion ended");

  ////////////////////////////////////////////////////////////////
  // thermostat outputs move only on a finished conversion
  chk_outputs_hold: assert property (
    !conv_done |=> $stable({temp_high_out, temp_low_out, temp_combo_out}))
    else $error("thermostat outputs moved without a conversion");
  chk_combo_high: assert property (temp_high_out |-> temp_combo_out)
    else $error("combo output low while over output high");
  chk_combo_rise: assert property ($rose(temp_combo_out) |-> temp_high_out)
    else $error("combo rose without reaching the high limit");
  chk_combo_fall: assert property ($fell(temp_combo_out) |-> temp_low_out)
    else $error("combo fell without reaching the low limit");

  cover property (conv_done && busy);
  cover property (dq_oe);
  cover property ($rose(temp_combo_out));
endmodule

bind tstc_top tstc_checker #(
  .NV_WRITE_CYC(NV_WRITE_CYC),
  .SA_PULSE_CYC(SA_PULSE_CYC)
) tstc_checker_inst (
  .mclk(mclk), .rst(rst), .frame(frame), .clock_convert_pin(clock_convert_pin),
  .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .conv_start(conv_start),
  .conv_done(conv_done), .conv_temp(conv_temp), .conv_count(conv_count),
  .conv_slope(conv_slope), .temp_high_out(temp_high_out),
  .temp_low_out(temp_low_out), .temp_combo_out(temp_combo_out)
);

//--- bench/tstc_meas_model.sv
`timescale 1ns/100ps
module tstc_meas_model
  import tstc_pkg::*;
(
  input  wire logic        mclk,        // core clock
  input  wire logic        rst,         // synchronous reset
  input  wire logic        conv_start,  // start pulse from the block
  input  wire logic [15:0] lat,         // cycles from start to done
  input  wire logic [8:0]  temp_set,    // temperature the next result reports
  output logic             conv_done,   // one-cycle end pulse
  output logic [8:0]       conv_temp,   // result words, valid with done only
  output logic [8:0]       conv_count,
  output logic [8:0]       conv_slope,
  output logic [15:0]      conv_total   // finished conversions, for the bench
);
  logic [15:0] left;  // cycles until the running conversion ends

  ////////////////////////////////////////////////////////////////
  // outside the done cycle the words toggle, so a stale read shows
  always @(posedge mclk) begin
    conv_done <= 1'b0;
    conv_temp <= ~conv_temp;
    conv_count <= ~conv_count;
    conv_slope <= ~conv_slope;
    if (rst) begin
      left <= 16'h0000;
      conv_total <= 16'h0000;
      conv_temp <= 9'h155;
      conv_count <= 9'h0aa;
      conv_slope <= 9'h133;
    end else if (conv_start) begin
      left <= lat;
    end else if (left == 16'h0001) begin
      // result handed over together with the done pulse
      conv_done <= 1'b1;
      conv_temp <= temp_set;
      conv_count <= ~temp_set;
      conv_slope <= temp_set + 9'h001;
      conv_total <= conv_total + 16'h0001;
      left <= 16'h0000;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
    end
  end
endmodule

//--- bench/tstc_bench.sv
`timescale 1ns/100ps
`include "tstc_regs.svh"
module tstc_bench
  import tstc_pkg::*;
;
  logic        mclk = 1'b0, rst = 1'b0, frame = 1'b0, pin = 1'b1;
  logic        tb_oe = 1'b0, tb_d = 1'b0, junk = 1'b0;
  logic        dq_o, dq_oe, conv_start, conv_done, hi, lo, co;
  wire logic   dq_i;
  logic [8:0]  conv_temp, conv_count, conv_slope;
  logic [8:0]  temp_set = 9'h000;
  logic [15:0] lat = 16'h000a, conv_total, mark;
  logic [9:0]  q;
  int          mismatches = 0, total_checks = 0;

  always #5 mclk = ~mclk;
  // a released line shows no memory of its last value
  always @(posedge mclk) junk <= ~junk;
  assign dq_i = dq_oe ? dq_o : (tb_oe ? tb_d : junk);

  tstc_top #(.NV_WRITE_CYC(40), .SA_PULSE_CYC(30)) tstc_top_inst (
    .mclk(mclk), .rst(rst), .frame(frame), .clock_convert_pin(pin), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe(dq_oe), .conv_start(conv_start), .conv_done(conv_done),
    .conv_temp(conv_temp), .conv_count(conv_count), .conv_slope(conv_slope),
    .temp_high_out(hi), .temp_low_out(lo), .temp_combo_out(co));
  tstc_meas_model tstc_meas_model_inst (
    .mclk(mclk), .rst(rst), .conv_start(conv_start), .lat(lat),
    .temp_set(temp_set), .conv_done(conv_done), .conv_temp(conv_temp),
    .conv_count(conv_count), .conv_slope(conv_slope), .conv_total(conv_total));

  ////////////////////////////////////////////////////////////////
  // helpers
  task check(input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // one frame: command lsb first, then n data bits in or out
  task xfer(input logic [7:0] c, input logic [9:0] d, input int n, output logic [9:0] r);
    r = 10'h000;
    frame = 1'b1;
    tb_oe = 1'b1;
    #40;
    for (int i = 0; i < 8 + n; i++) begin
      pin = 1'b0;
      if (i < 8) tb_d = c[i];
      else if (c[7]) tb_oe = 1'b0;
      else tb_d = d[i-8];
      #3;
      if (i >= 8) r[i-8] = dq_i;
      pin = 1'b1;
      #3;
    end
    frame = 1'b0;
    tb_oe = 1'b0;
    tick(16);  // gap keeps frames well apart
  endtask
  // reads run past the msb so trailing zeros are seen too
  task rd(input logic [7:0] c, input logic [9:0] e);
    xfer(c, 10'h000, 10, q);
    check(q, e);
  endtask
  task wr(input logic [7:0] c, input logic [9:0] d, input int n);
    xfer(c, d, n, q);
  endtask
  task outs(input logic [2:0] e);
    check({7'h00, hi, lo, co}, {7'h00, e});
  endtask
  task pulse(input int n);
    mark = conv_total;
    pin = 1'b0;
    tick(n);
    pin = 1'b1;
    tick(60);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // hang guard: the tests need about 21 us
  initial begin
    #200000;
    mismatches++;
    final_report;
  end

  ////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    #1 rst = 1'b1;
    tick(20);
    rst = 1'b0;
    tick(4);
    rd(`TSTC_CMD_RD_CFG, 10'h008);
    rd(`TSTC_CMD_RD_HIGH, 10'h000);
    $display("test reset finished");
    wr(`TSTC_CMD_WR_HIGH, 10'h050, 9);
    rd(`TSTC_CMD_RD_CFG, 10'h018);
    tick(50);
    rd(`TSTC_CMD_RD_CFG, 10'h008);
    wr(`TSTC_CMD_WR_LOW, 10'h014, 9);
    tick(50);
    wr(`TSTC_CMD_WR_LOW, 10'h1ff, 8);  // one bit short, must not land
    rd(`TSTC_CMD_RD_HIGH, 10'h050);
    rd(`TSTC_CMD_RD_LOW, 10'h014);
    $display("test limits finished");
    // one-shot: a single start gives a single conversion
    wr(`TSTC_CMD_WR_CFG, 10'h003, 8);
    tick(50);
    temp_set = 9'h060;
    mark = conv_total;
    wr(`TSTC_CMD_START, 10'h000, 0);
    tick(60);
    check(10'(conv_total - mark), 10'h001);
    rd(`TSTC_CMD_RD_TEMP, 10'h060);
    rd(`TSTC_CMD_RD_COUNT, 10'h19f);
    rd(`TSTC_CMD_RD_SLOPE, 10'h061);
    rd(`TSTC_CMD_RD_CFG, 10'h0cb);
    outs(3'b101);
    $display("test one-shot finished");
    // slow conversion: done reads low and outputs hold meanwhile
    temp_set = 9'h030;
    lat = 16'h012c;
    wr(`TSTC_CMD_START, 10'h000, 0);
    rd(`TSTC_CMD_RD_CFG, 10'h04b);
    outs(3'b101);
    tick(300);
    outs(3'b001);
    wr(`TSTC_CMD_WR_CFG, 10'h003, 8);
    tick(50);
    rd(`TSTC_CMD_RD_CFG, 10'h08b);
    lat = 16'h000a;
    temp_set = 9'h1ce;
    wr(`TSTC_CMD_START, 10'h000, 0);
    tick(60);
    outs(3'b010);
    rd(`TSTC_CMD_RD_CFG, 10'h0ab);
    $display("test thermostat finished");
    // continuous runs until stop, the running one still completes
    wr(`TSTC_CMD_WR_CFG, 10'h002, 8);
    tick(50);
    mark = conv_total;
    wr(`TSTC_CMD_START, 10'h000, 0);
    tick(100);
    check({9'h000, (conv_total - mark) > 16'h0003}, 10'h001);
    wr(`TSTC_CMD_STOP, 10'h000, 0);
    tick(30);
    mark = conv_total;
    tick(60);
    check(10'(conv_total - mark), 10'h000);
    $display("test continuous finished");
    // stand-alone with one-shot set: short pulse once, long pulse repeats
    wr(`TSTC_CMD_WR_CFG, 10'h001, 8);
    tick(50);
    pulse(10);
    check(10'(conv_total - mark), 10'h001);
    pulse(100);
    check({9'h000, (conv_total - mark) > 16'h0003}, 10'h001);
    mark = conv_total;
    tick(60);
    check(10'(conv_total - mark), 10'h000);
    wr(`TSTC_CMD_WR_CFG, 10'h003, 8);
    tick(50);
    pulse(10);
    check(10'(conv_total - mark), 10'h000);
    $display("test stand-alone finished");
    final_report;
  end
endmodule
